// *** verilog/cyclic_request_ack_handshake.sv ***
/*
 * Request/acknowledge handshake of the cyclic process data: the controller
 * writes the control module, the block answers with the status module and
 * drives trigger, job-change and run-switch requests into the sensor core.
 * Assumes: one Avalon-MM write to the control register per exchange cycle;
 * sensor core done/ok/error inputs are on core_clk_in; ready pin is async.
 * Every access costs one wait state; bytes 1 and 3 of the control word are ignored.
 * A run-switch success reported during a configuration session is held until it ends.
 */
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
module cyclic_request_ack_handshake (
    // Clock, reset and the Avalon-MM slave port
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Sensor core: the ready pin crosses in from outside, the rest is on core_clk_in
    input wire logic sensor_ready_pin_in,
    input wire logic free_run_mode_in,
    input wire logic config_session_active_in,
    input wire logic job_change_done_in,
    input wire logic job_change_ok_in,
    input wire logic run_switch_done_in,
    input wire logic run_switch_ok_in,
    input wire logic system_error_in,
    // Into the sensor core: one-cycle requests, the job target and the trigger inhibit level
    output logic trigger_pulse_out,
    output logic job_change_pulse_out,
    output logic [7:0] job_target_out,
    output logic run_switch_pulse_out,
    output logic hardware_trigger_inhibit_out
);
    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic [7:0] ctrl0;
        logic [7:0] job_req;
        logic trig_ack;
        logic job_ack;
        logic run_ack;
        logic job_busy;
        logic run_busy;
        // Success seen while a configuration session was still open
        logic run_wait;
        logic [3:0] err;
        logic [7:0] cur_job;
        logic [7:0] job_target;
        logic run_mode;
        logic trig_pulse;
        logic job_pulse;
        logic run_pulse;
    } hs_state_t;

    hs_state_t state;
    hs_state_t next_state;
    logic ready_sync;

    // Two stages trade two cycles of ready lag for freedom from metastability
    level_sync ready_sync_inst (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(sensor_ready_pin_in),
        .sync_out(ready_sync)
    );

    function automatic logic [7:0] merge_byte(input logic [7:0] old_val, input logic [7:0] new_val,
                                              input logic en);
        merge_byte = en ? new_val : old_val;
    endfunction

    function automatic logic [7:0] status_byte0(input hs_state_t s, input logic rdy);
        logic [7:0] b;
        b = handshake_pkg::BYTE_ZERO;
        b[handshake_pkg::STAT_READY] = rdy;
        b[handshake_pkg::STAT_TRIG_ACK] = s.trig_ack;
        b[handshake_pkg::STAT_JOB_ACK] = s.job_ack;
        b[handshake_pkg::STAT_RUN_ACK] = s.run_ack;
        status_byte0 = b;
    endfunction

    function automatic logic [7:0] status_byte5(input hs_state_t s, input logic free_run);
        logic [7:0] b;
        b = handshake_pkg::BYTE_ZERO;
        b[3:0] = s.err;
        b[handshake_pkg::STAT_TRIG_MODE] = free_run;
        b[handshake_pkg::STAT_OP_MODE] = s.run_mode;
        status_byte5 = b;
    endfunction

    // A request is a 0 to 1 change between two successive control writes
    function automatic logic [7:0] rising_bits(input logic [7:0] old_val, input logic [7:0] new_val);
        rising_bits = new_val & ~old_val;
    endfunction

    // Read mux; unmapped offsets read as zero
    function automatic logic [31:0] read_word(input hs_state_t s, input logic [3:0] addr, input logic rdy,
                                              input logic free_run);
        logic [31:0] w;
        w = handshake_pkg::WORD_ZERO;
        if (addr == handshake_pkg::CTRL_ADDR) begin
            w = {handshake_pkg::BYTE_ZERO, s.job_req, handshake_pkg::BYTE_ZERO, s.ctrl0};
        end else if (addr == handshake_pkg::STAT_LO_ADDR) begin
            w = {s.cur_job, handshake_pkg::BYTE_ZERO, handshake_pkg::BYTE_ZERO, status_byte0(s, rdy)};
        end else if (addr == handshake_pkg::STAT_HI_ADDR) begin
            w = {handshake_pkg::BYTE_ZERO, handshake_pkg::BYTE_ZERO, status_byte5(s, free_run),
                 handshake_pkg::BYTE_ZERO};
        end
        read_word = w;
    endfunction

    always_comb begin
        logic access;
        logic ctrl_wr;
        logic [7:0] new0;
        logic [7:0] rise;
        logic [3:0] err_next;
        logic run_fail;
        logic run_finish;
        access = 1'b0;
        ctrl_wr = 1'b0;
        new0 = state.ctrl0;
        rise = handshake_pkg::BYTE_ZERO;
        err_next = state.err;
        run_fail = 1'b0;
        run_finish = 1'b0;
        next_state = state;
        next_state.trig_pulse = 1'b0;
        next_state.job_pulse = 1'b0;
        next_state.run_pulse = 1'b0;

        // Waitrequest drops for exactly one cycle per request
        access = (avs_read_in || avs_write_in) && !state.waitreq;
        next_state.waitreq = !((avs_read_in || avs_write_in) && state.waitreq);

        // Read data load at the edge that drops waitrequest and stand until the next read
        if (avs_read_in && state.waitreq) begin
            next_state.rdata = read_word(state, avs_address_in, ready_sync, free_run_mode_in);
        end

        ctrl_wr = access && avs_write_in && (avs_address_in == handshake_pkg::CTRL_ADDR);
        if (ctrl_wr) begin
            new0 = merge_byte(state.ctrl0, avs_writedata_in[7:0], avs_byteenable_in[0]);
            next_state.job_req = merge_byte(state.job_req, avs_writedata_in[23:16], avs_byteenable_in[2]);
            rise = rising_bits(state.ctrl0, new0);
            next_state.ctrl0 = new0;
        end

        // Error reset is applied first so a new error in the same cycle survives
        if (rise[handshake_pkg::CTRL_ERR_RESET]) begin
            err_next = handshake_pkg::ERR_NONE;
        end

        // Trigger request
        if (rise[handshake_pkg::CTRL_TRIGGER]) begin
            if (ready_sync) begin
                next_state.trig_pulse = 1'b1;
                next_state.trig_ack = 1'b1;
            end else begin
                next_state.trig_ack = 1'b0;
                err_next = handshake_pkg::ERR_TRIGGER;
            end
        end else if (!new0[handshake_pkg::CTRL_TRIGGER]) begin
            next_state.trig_ack = 1'b0;
        end

        // Job change request; the byte-2 value is latched on the edge
        if (rise[handshake_pkg::CTRL_CHANGE_JOB] && !state.job_busy) begin
            // Job zero is answered at once, with no start pulse and no error
            if (next_state.job_req == handshake_pkg::JOB_NONE) begin
                next_state.job_ack = 1'b1;
            end else begin
                next_state.job_busy = 1'b1;
                next_state.job_pulse = 1'b1;
                next_state.job_target = next_state.job_req;
            end
        end else if (!new0[handshake_pkg::CTRL_CHANGE_JOB]) begin
            next_state.job_ack = 1'b0;
        end
        // Acknowledge waits on the core, however long it defers the change
        if (state.job_busy && job_change_done_in) begin
            next_state.job_busy = 1'b0;
            next_state.job_ack = new0[handshake_pkg::CTRL_CHANGE_JOB];
            if (job_change_ok_in) begin
                next_state.cur_job = state.job_target;
            end else begin
                err_next = handshake_pkg::ERR_CHANGE_JOB;
            end
        end

        // Switch to run request
        if (rise[handshake_pkg::CTRL_SWITCH_RUN] && !state.run_busy) begin
            next_state.run_busy = 1'b1;
            next_state.run_pulse = 1'b1;
        end else if (!new0[handshake_pkg::CTRL_SWITCH_RUN]) begin
            next_state.run_ack = 1'b0;
        end
        // Success is only believed once the configuration session is gone; a success
        // reported during the session is held, since the core reports it only once
        if (state.run_busy && run_switch_done_in && run_switch_ok_in && config_session_active_in) begin
            next_state.run_wait = 1'b1;
        end
        // A failure ends the request at once, session or not
        run_fail = state.run_busy && run_switch_done_in && !run_switch_ok_in;
        run_finish = state.run_busy && !config_session_active_in
            && (state.run_wait || (run_switch_done_in && run_switch_ok_in));
        if (run_fail || run_finish) begin
            next_state.run_busy = 1'b0;
            next_state.run_wait = 1'b0;
            next_state.run_ack = new0[handshake_pkg::CTRL_SWITCH_RUN];
            if (!run_fail) begin
                next_state.run_mode = 1'b1;
            end else begin
                next_state.run_mode = 1'b0;
                err_next = handshake_pkg::ERR_SWITCH_RUN;
            end
        end

        if (system_error_in) begin
            err_next = handshake_pkg::ERR_SYSTEM;
        end
        next_state.err = err_next;
    end

    // Waitrequest resets high so nothing is taken while the block leaves reset
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= '0;
            state.waitreq <= 1'b1;
            state.cur_job <= handshake_pkg::JOB_RESET;
            state.job_target <= handshake_pkg::JOB_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Every output is a field of the state register
    assign avs_readdata_out = state.rdata;
    assign avs_waitrequest_out = state.waitreq;
    assign trigger_pulse_out = state.trig_pulse;
    assign job_change_pulse_out = state.job_pulse;
    assign job_target_out = state.job_target;
    assign run_switch_pulse_out = state.run_pulse;
    assign hardware_trigger_inhibit_out = state.ctrl0[handshake_pkg::CTRL_HW_TRIG_INHIBIT];
endmodule

// *** common/handshake_pkg.sv ***
/*
 * Constants for the cyclic request/acknowledge handshake block: register
 * offsets, bit positions of the control and status modules, error codes.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package handshake_pkg;
    // Register byte addresses
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STAT_LO_ADDR = 4'h4;
    localparam logic [3:0] STAT_HI_ADDR = 4'h8;
    localparam int ADDR_W = 4;

    // Control byte 0 bits
    localparam int CTRL_ERR_RESET = 0;
    localparam int CTRL_HW_TRIG_INHIBIT = 1;
    localparam int CTRL_TRIGGER = 2;
    localparam int CTRL_CHANGE_JOB = 3;
    localparam int CTRL_SWITCH_RUN = 4;

    // Status byte 0 bits
    localparam int STAT_READY = 0;
    localparam int STAT_TRIG_ACK = 2;
    localparam int STAT_JOB_ACK = 3;
    localparam int STAT_RUN_ACK = 4;

    // Status byte 5 bits
    localparam int STAT_TRIG_MODE = 4;
    localparam int STAT_OP_MODE = 6;

    // Error codes
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_TRIGGER = 4'h1;
    localparam logic [3:0] ERR_CHANGE_JOB = 4'h2;
    localparam logic [3:0] ERR_SWITCH_RUN = 4'h3;
    localparam logic [3:0] ERR_SYSTEM = 4'hF;

    // Job values (no job, reset job) and zero fill constants
    localparam logic [7:0] JOB_NONE = 8'h00;
    localparam logic [7:0] JOB_RESET = 8'h01;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// *** verilog/level_sync.sv ***
/*
 * Two-flop synchroniser for one asynchronous level.
 * Assumes the input may change at any time relative to core_clk_in.
 */
`timescale 1ns/10ps
module level_sync (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic meta;
        logic stable;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb begin
        next_state.meta = async_in;
        // Only the second stage reads the first
        next_state.stable = state.meta;
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stable;
endmodule

// *** dv/cyclic_request_ack_handshake_assertions.sv ***
/* Port checker for the handshake block.
   Assumes it is bound into every instance of the block. */
`timescale 1ns/10ps
module cyclic_request_ack_handshake_assertions (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic sensor_ready_pin_in,
    input wire logic trigger_pulse_out,
    input wire logic job_change_pulse_out,
    input wire logic [7:0] job_target_out,
    input wire logic run_switch_pulse_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic ctrl_done;
    assign ctrl_done = avs_write_in && !avs_waitrequest_out && avs_address_in == handshake_pkg::CTRL_ADDR
        && avs_byteenable_in[0];
    sequence job_zero_s;
        ctrl_done && avs_writedata_in[3] && avs_byteenable_in[2] && avs_writedata_in[23:16] == 8'h00;
    endsequence
    chk_trig_cause: assert property (trigger_pulse_out |-> $past(ctrl_done && avs_writedata_in[2]))
        else $error("trigger pulse without a request");
    chk_trig_single: assert property (trigger_pulse_out |=> !trigger_pulse_out)
        else $error("trigger pulse longer than one cycle");
    // Sync lag is two flops, so a window of three samples is allowed
    chk_trig_ready: assert property (trigger_pulse_out |-> $past(sensor_ready_pin_in, 2)
        || $past(sensor_ready_pin_in, 3) || $past(sensor_ready_pin_in, 4)) else $error("trigger while not ready");
    chk_job_target: assert property (job_change_pulse_out |-> job_target_out != 8'h00
        && job_target_out == $past(avs_writedata_in[23:16])) else $error("wrong job target");
    chk_job_zero: assert property (job_zero_s |=> !job_change_pulse_out)
        else $error("job change started for job zero");
    chk_run_cause: assert property (run_switch_pulse_out |-> $past(ctrl_done && avs_writedata_in[4]))
        else $error("run switch without a request");
    chk_wait_one: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for two cycles");
    chk_unmapped_read: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in == 4'hC
        |-> avs_readdata_out == 32'h0000_0000) else $error("unmapped read not zero");
endmodule
bind cyclic_request_ack_handshake cyclic_request_ack_handshake_assertions chk (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .sensor_ready_pin_in(sensor_ready_pin_in),
    .trigger_pulse_out(trigger_pulse_out),
    .job_change_pulse_out(job_change_pulse_out),
    .job_target_out(job_target_out),
    .run_switch_pulse_out(run_switch_pulse_out)
);

// *** dv/sensor_core_model.sv ***
/* Behavioural sensor core answering job change and run switch.
   Assumes one-cycle start pulses on the block clock. */
`timescale 1ns/10ps
module sensor_core_model #(parameter int DELAY = 6) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic job_pulse_in,
    input wire logic run_pulse_in,
    input wire logic job_ok_in,
    input wire logic run_ok_in,
    output logic job_done_out,
    output logic job_ok_out,
    output logic run_done_out,
    output logic run_ok_out
);
    int jc;
    int rc;
    // Completion is deferred by DELAY cycles
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            jc <= 0;
            rc <= 0;
        end else begin
            jc <= job_pulse_in ? DELAY : (jc > 0 ? jc - 1 : 0);
            rc <= run_pulse_in ? DELAY : (rc > 0 ? rc - 1 : 0);
        end
    end
    assign job_done_out = jc == 1;
    assign run_done_out = rc == 1;
    // Outcome lines show the opposite value outside done
    assign job_ok_out = job_done_out ? job_ok_in : !job_ok_in;
    assign run_ok_out = run_done_out ? run_ok_in : !run_ok_in;
endmodule

// *** dv/cyclic_request_ack_handshake_tb_top.sv ***
/* Self-checking bench: register accesses over Avalon-MM.
   Assumes the sensor core model answers job and run requests. */
`timescale 1ns/10ps
module cyclic_request_ack_handshake_tb_top;
    logic clk = 0;
    logic rst = 1;
    logic [3:0] addr = 4'h0;
    logic rd = 0;
    logic wr = 0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [31:0] rdv;
    logic wait_o;
    logic pin = 1;
    logic free_run = 0;
    logic cfg = 0;
    logic sys_err = 0;
    logic job_ok = 1;
    logic run_ok = 1;
    logic jd, jo, rdn, ro, tp, jp, rp, inh;
    logic [7:0] jt;
    int errors = 0;
    int check_count = 0;
    initial begin
        forever #10 clk = !clk;
    end
    cyclic_request_ack_handshake dut (.core_clk_in(clk), .sys_rst_in(rst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o), .sensor_ready_pin_in(pin),
        .free_run_mode_in(free_run), .config_session_active_in(cfg), .job_change_done_in(jd),
        .job_change_ok_in(jo), .run_switch_done_in(rdn), .run_switch_ok_in(ro), .system_error_in(sys_err),
        .trigger_pulse_out(tp), .job_change_pulse_out(jp), .job_target_out(jt), .run_switch_pulse_out(rp),
        .hardware_trigger_inhibit_out(inh));
    sensor_core_model core (.clk_in(clk), .rst_in(rst), .job_pulse_in(jp), .run_pulse_in(rp),
        .job_ok_in(job_ok), .run_ok_in(run_ok), .job_done_out(jd), .job_ok_out(jo), .run_done_out(rdn),
        .run_ok_out(ro));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task acc(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wait_o !== 1'b0 && n < 20);
        rdv = rdata;
        wr <= 0;
        rd <= 0;
        @(posedge clk);
        if (n >= 20) errors++;
    endtask
    task wr_ctrl(input logic [31:0] d);
        acc(handshake_pkg::CTRL_ADDR, 1, d);
    endtask
    task rd_lo(input logic [31:0] exp);
        acc(handshake_pkg::STAT_LO_ADDR, 0, 32'h0000_0000);
        check(rdv, exp);
    endtask
    task rd_hi(input logic [31:0] exp);
        acc(handshake_pkg::STAT_HI_ADDR, 0, 32'h0000_0000);
        check(rdv, exp);
    endtask
    // Bounded poll until an acknowledge bit shows
    task poll(input logic [31:0] mask);
        int n;
        n = 0;
        do begin
            acc(handshake_pkg::STAT_LO_ADDR, 0, 32'h0000_0000);
            n++;
        end while ((rdv & mask) == 0 && n < 30);
        // A poll that runs out counts as a mismatch
        if ((rdv & mask) == 0) errors++;
    endtask
    task finish_test;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        finish_test;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        // The ready pin needs both synchroniser stages loaded before it shows
        repeat (3) @(posedge clk);
        rd_lo(32'h0100_0001);
        rd_hi(32'h0000_0000);
        acc(4'hC, 0, 32'h0000_0000);
        check(rdv, 32'h0000_0000);
        wr_ctrl(32'h0000_0004);
        rd_lo(32'h0100_0005);
        wr_ctrl(32'h0000_0000);
        rd_lo(32'h0100_0001);
        pin <= 0;
        repeat (4) @(posedge clk);
        rd_lo(32'h0100_0000);
        wr_ctrl(32'h0000_0004);
        rd_lo(32'h0100_0000);
        rd_hi(32'h0000_0100);
        wr_ctrl(32'h0000_0001);
        rd_hi(32'h0000_0000);
        pin <= 1;
        wr_ctrl(32'h0000_0008);
        rd_lo(32'h0100_0009);
        wr_ctrl(32'h0000_0000);
        wr_ctrl(32'h00AA_0008);
        poll(32'h0000_0008);
        rd_lo(32'hAA00_0009);
        wr_ctrl(32'h0000_0000);
        rd_lo(32'hAA00_0001);
        job_ok <= 0;
        wr_ctrl(32'h0033_0008);
        poll(32'h0000_0008);
        rd_lo(32'hAA00_0009);
        rd_hi(32'h0000_0200);
        wr_ctrl(32'h0000_0000);
        cfg <= 1;
        wr_ctrl(32'h0000_0011);
        repeat (20) @(posedge clk);
        rd_lo(32'hAA00_0001);
        cfg <= 0;
        poll(32'h0000_0010);
        rd_lo(32'hAA00_0011);
        rd_hi(32'h0000_4000);
        wr_ctrl(32'h0000_0000);
        rd_lo(32'hAA00_0001);
        run_ok <= 0;
        wr_ctrl(32'h0000_0010);
        poll(32'h0000_0010);
        rd_hi(32'h0000_0300);
        wr_ctrl(32'h0000_0000);
        sys_err <= 1;
        @(posedge clk);
        sys_err <= 0;
        rd_hi(32'h0000_0F00);
        free_run <= 1;
        wr_ctrl(32'h0000_0002);
        check(32'(inh), 32'h0000_0001);
        rd_hi(32'h0000_1F00);
        finish_test;
    end
endmodule
